// File: rtl/gbp_pwm.sv
// Purpose: Blink/PWM generator behind five general-purpose pins
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes:   PWM logic advances on a divided 32.768 kHz enable
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "gbp_cfg.svh"
module gbp_pwm #(
   parameter int NUM_PINS = `GBP_NUM_PINS,
   parameter int CLK_HZ   = `GBP_CLK_HZ
) (
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire gbp_pkg::gbp_bus_req_t bus,
   output logic [31:0]               rdata,
   output logic [NUM_PINS-1:0]       blink_capable_pins_out,
   output logic [NUM_PINS-1:0]       blink_capable_pins_oe_n
);
   import gbp_pkg::*;

   localparam int CW = `GBP_CNT_W;
   localparam int TW = `GBP_THR_W;

   logic                      pwm_tick;
   gbp_ctrl_t                 pwm_control_word [NUM_PINS];
   gbp_ctrl_t                 active           [NUM_PINS];
   gbp_pad_t                  pad              [NUM_PINS];
   logic [CW-1:0]             cnt              [NUM_PINS];
   logic [NUM_PINS-1:0]       pwm_out;
   logic [31:0]               next_rdata;

   // PWM clock enable
   gbp_tick_div #(
      .CLK_HZ  (CLK_HZ),
      .TICK_HZ (`GBP_PWM_CLK_HZ)
   ) u_tick (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (pwm_tick)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_ch
         localparam logic [7:0] CTRL_A = 8'(`GBP_CTRL_BASE + 4 * g);
         localparam logic [7:0] PAD_A  = 8'(`GBP_PAD_BASE + 4 * g);
         gbp_ctrl_t     next_ctrl;
         gbp_ctrl_t     next_active;
         gbp_pad_t      next_pad;
         logic [CW:0]   sum;
         logic [CW-1:0] next_cnt;
         logic          next_out;
         logic          period_start;
         logic          wr_ctrl;

         always_comb begin
            wr_ctrl      = bus.we && (bus.addr == CTRL_A);
            next_ctrl    = pwm_control_word[g];
            next_active  = active[g];
            next_pad     = pad[g];
            next_cnt     = cnt[g];
            next_out     = pwm_out[g];
            period_start = 1'b0;
            // Counter step: 8.8 increment placed so 1.0 wraps in 256 ticks
            sum = {1'b0, cnt[g]} + {1'b0, active[g].base, 8'h00};
            if (!active[g].en) begin
               next_cnt = '0;
               next_out = 1'b0;
               period_start = 1'b1;   // Idle: pending settings apply at once
            end else if (pwm_tick) begin
               if (active[g].base == '0) begin
                  next_out = 1'b0;
               end else if (active[g].base > `GBP_BASE_MAX_RES) begin
                  next_cnt = '0;
                  next_out = ~pwm_out[g];
                  period_start = pwm_out[g];
               end else if (sum[CW]) begin
                  next_cnt = '0;
                  next_out = 1'b0;
                  period_start = 1'b1;
               end else begin
                  next_cnt = sum[CW-1:0];
                  next_out = (sum[CW-1:CW-TW] >= active[g].thr);
               end
            end
            if (period_start && pwm_control_word[g].upd) begin
               next_active.base = pwm_control_word[g].base;
               next_active.thr  = pwm_control_word[g].thr;
               next_ctrl.upd    = 1'b0;
            end
            next_active.en  = pwm_control_word[g].en;
            next_active.upd = 1'b0;
            if (wr_ctrl) begin
               next_ctrl.thr  = bus.wdata[`GBP_CTRL_THR_LSB +: TW];
               next_ctrl.base = bus.wdata[`GBP_CTRL_BASE_LSB +: `GBP_BASE_W];
               next_ctrl.en   = bus.wdata[`GBP_CTRL_EN_BIT];
               // Set wins over the hardware clear
               next_ctrl.upd  = pwm_control_word[g].upd | bus.wdata[`GBP_CTRL_UPD_BIT];
               if (bus.wdata[`GBP_CTRL_UPD_BIT]) begin
                  next_ctrl.upd = 1'b1;
               end else if (period_start) begin
                  next_ctrl.upd = next_ctrl.upd & ~pwm_control_word[g].upd;
               end
            end
            if (bus.we && (bus.addr == PAD_A)) begin
               next_pad.mode = bus.wdata[`GBP_PAD_MODE_LSB +: `GBP_MODE_W];
               next_pad.txv  = bus.wdata[`GBP_PAD_TXV_BIT];
               next_pad.txe  = bus.wdata[`GBP_PAD_TXE_BIT];
            end
         end

         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               pwm_control_word[g] <= gbp_ctrl_t'(`GBP_CTRL_RESET);
               active[g]           <= gbp_ctrl_t'(`GBP_CTRL_RESET);
               pad[g]              <= gbp_pad_t'(`GBP_PAD_RESET);
               cnt[g]              <= '0;
               pwm_out[g]          <= 1'b0;
               blink_capable_pins_out[g]  <= 1'b0;
               blink_capable_pins_oe_n[g] <= 1'b1;
            end else begin
               pwm_control_word[g] <= next_ctrl;
               active[g]           <= next_active;
               pad[g]              <= next_pad;
               cnt[g]              <= next_cnt;
               pwm_out[g]          <= next_out;
               // Pad mux: blink function or plain GPIO
               if (pad[g].mode == `GBP_PAD_MODE_BLINK) begin
                  blink_capable_pins_out[g]  <= pwm_out[g];
                  blink_capable_pins_oe_n[g] <= 1'b0;
               end else begin
                  blink_capable_pins_out[g]  <= pad[g].txv;
                  blink_capable_pins_oe_n[g] <= ~pad[g].txe;
               end
            end
         end
      end
   endgenerate

   // Read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (bus.addr == 8'(`GBP_CTRL_BASE + 4 * i)) begin
            next_rdata[`GBP_CTRL_THR_LSB +: TW]          = pwm_control_word[i].thr;
            next_rdata[`GBP_CTRL_BASE_LSB +: `GBP_BASE_W] = pwm_control_word[i].base;
            next_rdata[`GBP_CTRL_EN_BIT]                 = pwm_control_word[i].en;
            next_rdata[`GBP_CTRL_UPD_BIT]                = pwm_control_word[i].upd;
         end
         if (bus.addr == 8'(`GBP_PAD_BASE + 4 * i)) begin
            next_rdata[`GBP_PAD_MODE_LSB +: `GBP_MODE_W] = pad[i].mode;
            next_rdata[`GBP_PAD_TXV_BIT]                 = pad[i].txv;
            next_rdata[`GBP_PAD_TXE_BIT]                 = pad[i].txe;
         end
         if (bus.addr == 8'(`GBP_STAT_BASE + 4 * i)) begin
            next_rdata[`GBP_STAT_CNT_LSB +: TW] = cnt[i][CW-1:CW-TW];
            next_rdata[`GBP_STAT_OUT_BIT]       = pwm_out[i];
            next_rdata[`GBP_STAT_BUSY_BIT]      = active[i].en;
         end
      end
      if (!bus.re) begin
         next_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end
endmodule : gbp_pwm

// File: shared/gbp_cfg.svh
// Purpose: Offsets, field positions, reset values and timing figures of the blink/PWM block
// Assumes: 32-bit register port, byte addresses
// Notes:   Definitions only
`ifndef GBP_CFG_SVH
`define GBP_CFG_SVH

`define GBP_CLK_HZ          20000000
`define GBP_PWM_CLK_HZ      32768
`define GBP_PWM_CLK_FRAC    7

`define GBP_NUM_PINS        5
`define GBP_CNT_W           24
`define GBP_BASE_W          16
`define GBP_THR_W           8
`define GBP_MODE_W          4

`define GBP_CTRL_BASE       8'h00
`define GBP_PAD_BASE        8'h20
`define GBP_STAT_BASE       8'h40

`define GBP_CTRL_THR_LSB    0
`define GBP_CTRL_BASE_LSB   8
`define GBP_CTRL_EN_BIT     30
`define GBP_CTRL_UPD_BIT    31
`define GBP_PAD_MODE_LSB    0
`define GBP_PAD_TXV_BIT     8
`define GBP_PAD_TXE_BIT     9
`define GBP_STAT_CNT_LSB    0
`define GBP_STAT_OUT_BIT    8
`define GBP_STAT_BUSY_BIT   9

`define GBP_PAD_MODE_BLINK  4'h4
`define GBP_BASE_MAX_RES    16'h8000
`define GBP_CTRL_RESET      26'h000_0000
`define GBP_PAD_RESET       6'h00

`endif

// File: shared/gbp_pkg.sv
// Purpose: Types shared by the blink/PWM block
// Assumes: Constants come from gbp_cfg.svh
// Notes:   Base increment is unsigned 8.8 fixed point
`include "gbp_cfg.svh"
package gbp_pkg;
   typedef struct packed {
      logic                     upd;
      logic                     en;
      logic [`GBP_BASE_W-1:0]   base;
      logic [`GBP_THR_W-1:0]    thr;
   } gbp_ctrl_t;

   typedef struct packed {
      logic                     txe;
      logic                     txv;
      logic [`GBP_MODE_W-1:0]   mode;
   } gbp_pad_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } gbp_bus_req_t;
endpackage : gbp_pkg

// File: rtl/gbp_tick_div.sv
// Purpose: Fractional divider making a one-cycle enable at the PWM clock rate
// Assumes: CLK_HZ above TICK_HZ
// Notes:   Average rate exact, jitter one system clock
`timescale 1ns/1ps
`include "gbp_cfg.svh"
module gbp_tick_div #(
   parameter int CLK_HZ  = `GBP_CLK_HZ,
   parameter int TICK_HZ = `GBP_PWM_CLK_HZ
) (
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      tick
);
   import gbp_pkg::*;
   localparam logic [31:0] STEP = 32'(TICK_HZ);
   localparam logic [31:0] WRAP = 32'(CLK_HZ);
   logic [31:0] acc;
   logic [31:0] next_acc;
   logic        next_tick;

   always_comb begin
      next_tick = 1'b0;
      next_acc  = acc + STEP;
      if (next_acc >= WRAP) begin
         next_acc  = next_acc - WRAP;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc  <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         acc  <= next_acc;
         tick <= next_tick;
      end
   end
endmodule : gbp_tick_div

// File: verification/gbp_pwm_monitor.sv
// Purpose: Port checker for gbp_pwm
// Assumes: PWM tick every 10 clocks
// Notes:   Bound to gbp_pwm below
`timescale 1ns/1ps
module gbp_pwm_monitor #(
   parameter int NUM_PINS = 5
) (
   input wire logic                  clk,
   input wire logic                  arst_n,
   input wire gbp_pkg::gbp_bus_req_t bus,
   input wire logic [31:0]           rdata,
   input wire logic [NUM_PINS-1:0]   blink_capable_pins_out,
   input wire logic [NUM_PINS-1:0]   blink_capable_pins_oe_n
);
   import gbp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_pad_gpio;
      bus.we && bus.addr == 8'h20 && bus.wdata[3:0] != 4'h4 ##1 !bus.we [*3];
   endsequence
   sequence s_upd_off;
      bus.we && bus.addr == 8'h00 && bus.wdata[31:30] == 2'b10 ##1 !bus.we [*2] ##1 bus.re && bus.addr == 8'h00;
   endsequence
   sequence s_en_on;
      bus.we && bus.addr == 8'h00 && bus.wdata[30] ##1 !bus.we [*2] ##1 bus.re && bus.addr == 8'h40;
   endsequence
   AST_RDATA_IDLE: assert property (!bus.re |=> rdata == 32'h0)
      else $error("rdata not zero after idle cycle");
   AST_UNMAPPED_RD: assert property (bus.re && bus.addr >= 8'h54 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_GPIO_VAL: assert property (s_pad_gpio |-> blink_capable_pins_out[0] == $past(bus.wdata[8], 3))
      else $error("pin value not GPIO value");
   AST_GPIO_OE: assert property (s_pad_gpio |-> blink_capable_pins_oe_n[0] == !$past(bus.wdata[9], 3))
      else $error("pin enable not GPIO enable");
   AST_OE_CAUSE: assert property ($changed(blink_capable_pins_oe_n) |-> $past(bus.we) || $past(bus.we, 2))
      else $error("pin enable changed without write");
   AST_PIN_TICK: assert property ((!bus.we [*3]) ##0 $changed(blink_capable_pins_out) ##1 !bus.we [*4]
      |-> $stable(blink_capable_pins_out))
      else $error("pin changed faster than PWM clock");
   AST_UPD_CLR: assert property (s_upd_off |=> rdata[31] == 1'b0)
      else $error("update request not cleared");
   AST_STAT_EN: assert property (s_en_on |=> rdata[9] == 1'b1)
      else $error("enable not active");
endmodule : gbp_pwm_monitor

bind gbp_pwm gbp_pwm_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
   .blink_capable_pins_out(blink_capable_pins_out), .blink_capable_pins_oe_n(blink_capable_pins_oe_n));

// File: verification/tb_top.sv
// Purpose: Self-checking bench for gbp_pwm
// Assumes: CLK_HZ 327680, one PWM tick every 10 clocks
// Notes:   Pin 0 carries the waveform
`timescale 1ns/1ps
module tb_top;
   import gbp_pkg::*;
   logic         clk = 1'b0;
   logic         arst_n = 1'b0;
   gbp_bus_req_t bus = '0;
   logic [31:0]  rdata;
   logic [4:0]   pin_out;
   logic [4:0]   pin_oe_n;
   int           fail_count = 0;
   int           n_checks = 0;
   logic [31:0]  d;
   int           hi, per, pt, thr;
   logic [15:0]  bases [6] = '{16'h0100, 16'h0200, 16'h0b00, 16'h0500, 16'h0080, 16'h8100};
   always #25 clk = ~clk;
   gbp_pwm #(.CLK_HZ(327680)) u_dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
      .blink_capable_pins_out(pin_out), .blink_capable_pins_oe_n(pin_oe_n));
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      bus.we <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a);
      @(posedge clk);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus.re <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic wait_lvl(logic v);
      int k;
      k = 0;
      while (pin_out[0] !== v) begin
         @(posedge clk);
         k++;
         if (k > 12000) begin
            chk("pin wait", 32'h1, 32'h0);
            conclude();
         end
      end
   endtask : wait_lvl
   task automatic measure;
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      hi = 0;
      per = 0;
      for (int s = 1; s >= 0; s--) begin
         while (pin_out[0] === 1'(s) && per < 12000) begin
            @(posedge clk);
            per++;
            hi += s;
         end
      end
   endtask : measure
   function automatic int exp_hi(logic [15:0] b, int t);
      int n;
      n = 0;
      if (b > 16'h8000)
         return 1;
      for (int j = 1; j * b < 65536; j++)
         n += int'(((j * b) >> 8) >= t);
      return n;
   endfunction : exp_hi
   initial begin
      void'($urandom(32'h529f5ecf));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      #1 chk("reset oe_n", 32'h1f, pin_oe_n);
      chk("reset out", 32'h0, pin_out);
      for (int i = 0; i < 5; i++) begin
         rd(8'(4 * i));
         chk("ctrl reset", 32'h0, d);
         rd(8'(8'h20 + 4 * i));
         chk("pad reset", 32'h0, d);
      end
      wr(8'h54, 32'hffff_ffff);
      rd(8'h54);
      chk("unmapped", 32'h0, d);
      for (int i = 0; i < 5; i++) begin
         d = $urandom & 32'h0000_030f;
         if (d[3:0] == 4'h4)
            d[3:0] = 4'h3;
         wr(8'(8'h20 + 4 * i), d);
         repeat (3) @(posedge clk);
         chk("gpio out", 32'(d[8]), 32'(pin_out[i]));
         chk("gpio oe_n", 32'(!d[9]), 32'(pin_oe_n[i]));
      end
      wr(8'h00, 32'h8001_0000);
      @(posedge clk);
      rd(8'h00);
      chk("upd idle", 32'h0, 32'(d[31]));
      wr(8'h00, 32'h4001_0000);
      @(posedge clk);
      rd(8'h40);
      chk("enable", 32'h1, 32'(d[9]));
      wr(8'h20, 32'h4);
      for (int k = 0; k < 6; k++) begin
         pt = (bases[k] > 16'h8000) ? 2 : (65535 + bases[k]) / bases[k];
         thr = ((pt - 1) * bases[k]) >> 8;
         thr = (k == 0) ? 0 : (k == 1) ? thr : $urandom_range(thr);
         wr(8'h00, {2'b11, 6'h00, bases[k], 8'(thr)});
         rd(8'h00);
         if (pt >= 256)
            chk("upd pending", 32'h1, 32'(d[31]));
         measure();
         measure();
         chk("period", 32'(pt * 10), 32'(per));
         chk("high", 32'(exp_hi(bases[k], thr) * 10), 32'(hi));
         rd(8'h00);
         chk("upd done", 32'h0, 32'(d[31]));
      end
      wr(8'h00, 32'hc000_0080);
      repeat (100) @(posedge clk);
      hi = 0;
      repeat (300) begin
         @(posedge clk);
         hi += pin_out[0];
      end
      chk("flat low", 32'h0, 32'(hi));
      conclude();
   end
endmodule : tb_top
